// ===== pitc_ctrl.sv
// Priority interrupt and trap controller with an AXI4-Lite register slave.
// Assumes peripheral requests and trap events are one-cycle pulses on aclk;
// external request pins are asynchronous and are synchronised here.
`include "pitc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module pitc_ctrl
  import pitc_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Interrupt sources
  input wire logic [15:0] periph_req,
  input wire logic [2:0] ext_irq_pin,
  // Trap events from the core
  input wire logic trap_ovf_a,
  input wire logic trap_ovf_b,
  input wire logic trap_cat_a,
  input wire logic trap_cat_b,
  input wire logic trap_shift,
  input wire logic trap_div0,
  input wire logic trap_dma,
  input wire logic trap_addr,
  input wire logic trap_stack,
  input wire logic trap_osc,
  // Core side
  output logic irq_req,
  output logic [6:0] irq_vector,
  output logic [3:0] irq_level,
  input wire logic irq_ack,
  output logic alternate_table_select
);

  pitc_state_t st_reg;
  pitc_state_t st_next;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] val,
                                          input logic [1:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = val[7:0];
    end
    if (strb[1]) begin
      r[15:8] = val[15:8];
    end
    return r;
  endfunction

  logic [15:0] src_evt;
  logic [15:0] trap_set;
  logic math_evt;
  logic trap_evt;
  logic [3:0] cur_level;
  logic win_found;
  logic [3:0] win_idx;
  logic [2:0] win_prio;
  logic [2:0] prio_i;
  logic [15:0] wval;
  logic [15:0] rval;
  logic r_ok;
  logic w_ok;
  logic do_write;
  logic [2:0] ext_edge;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    st_next = st_reg;

    // External pins: sync2 is the first stage any logic may look at
    st_next.sync1 = ext_irq_pin;
    st_next.sync2 = st_reg.sync1;
    st_next.sync3 = st_reg.sync2;
    for (int e = 0; e < 3; e++) begin
      // Polarity 1 takes the falling edge, 0 the rising edge
      ext_edge[e] = st_reg.ext_edge_polarity[e] ? (st_reg.sync3[e] & ~st_reg.sync2[e])
                                                : (st_reg.sync2[e] & ~st_reg.sync3[e]);
    end
    src_evt = periph_req;
    src_evt[0] = periph_req[0] | ext_edge[0];
    src_evt[`PITC_EXT1_SRC] = periph_req[`PITC_EXT1_SRC] | ext_edge[1];
    src_evt[`PITC_EXT2_SRC] = periph_req[`PITC_EXT2_SRC] | ext_edge[2];

    // Trap status events, gated by their enables where they have one
    math_evt = trap_shift | trap_div0;
    trap_set = '0;
    trap_set[`PITC_OVA_FLAG] = trap_ovf_a & st_reg.global_ctrl_one[`PITC_OVA_EN];
    trap_set[`PITC_OVB_FLAG] = trap_ovf_b & st_reg.global_ctrl_one[`PITC_OVB_EN];
    trap_set[`PITC_COVA_FLAG] = trap_cat_a & st_reg.global_ctrl_one[`PITC_COV_EN];
    trap_set[`PITC_COVB_FLAG] = trap_cat_b & st_reg.global_ctrl_one[`PITC_COV_EN];
    trap_set[`PITC_SHIFT_FLAG] = trap_shift;
    trap_set[`PITC_DIV0_FLAG] = trap_div0;
    trap_set[`PITC_DMA_FLAG] = trap_dma;
    trap_set[`PITC_MATH_FLAG] = math_evt;
    trap_set[`PITC_ADDR_FLAG] = trap_addr;
    trap_set[`PITC_STACK_FLAG] = trap_stack;
    trap_set[`PITC_OSC_FLAG] = trap_osc;
    trap_evt = |trap_set;

    // Arbitration: strict compare keeps the lower vector on a tie
    cur_level = {st_reg.cpu_level_top_bit, st_reg.cpu_priority_level};
    win_found = 1'b0;
    win_idx = 4'h0;
    win_prio = 3'h0;
    for (int i = 0; i < 16; i++) begin
      prio_i = st_reg.source_priority_regs[i / 4][(i % 4) * 4 +: 3];
      if (st_reg.request_flag_regs[i] && st_reg.source_enable_regs[i]
          && ({1'b0, prio_i} > cur_level)
          && (!win_found || prio_i > win_prio)) begin
        win_found = 1'b1;
        win_idx = 4'(i);
        win_prio = prio_i;
      end
    end
    st_next.irq_req = win_found;
    st_next.irq_vector = `PITC_VEC_BASE + {3'h0, win_idx};
    st_next.irq_level = {1'b0, win_prio};

    // Write channel: address and data may arrive in either order
    if (awvalid && st_reg.awready) begin
      st_next.aw_have = 1'b1;
      st_next.aw_addr = awaddr;
    end
    if (wvalid && st_reg.wready) begin
      st_next.w_have = 1'b1;
      st_next.w_data = wdata[15:0];
      st_next.w_strb = wstrb[1:0];
    end
    do_write = st_reg.aw_have && st_reg.w_have;
    w_ok = 1'b0;
    wval = st_reg.w_data;
    if (do_write) begin
      w_ok = 1'b1;
      case (st_reg.aw_addr)
        `PITC_CPU_STATUS_WORD_OFS: begin
          if (!st_reg.global_ctrl_one[`PITC_NEST_DIS] && st_reg.w_strb[0]) begin
            st_next.cpu_priority_level = wval[`PITC_LEVEL_LSB +: 3];
          end
        end
        `PITC_CORE_CONTROL_WORD_OFS: begin
          // Software may only clear the top bit, never set it
          if (st_reg.w_strb[0] && !wval[`PITC_TOP_BIT]) begin
            st_next.cpu_level_top_bit = 1'b0;
          end
        end
        `PITC_GLOBAL_CTRL_ONE_OFS: begin
          st_next.global_ctrl_one = merge16(st_reg.global_ctrl_one, wval, st_reg.w_strb)
                                    & `PITC_CTRL_ONE_MASK;
        end
        `PITC_GLOBAL_CTRL_TWO_OFS: begin
          if (st_reg.w_strb[1]) begin
            st_next.alternate_table_select = wval[`PITC_ALT_TABLE];
          end
          if (st_reg.w_strb[0]) begin
            st_next.ext_edge_polarity = wval[2:0];
          end
        end
        `PITC_REQUEST_FLAG_OFS: begin
          st_next.request_flag_regs = merge16(st_reg.request_flag_regs, wval, st_reg.w_strb);
        end
        `PITC_SOURCE_ENABLE_OFS: begin
          st_next.source_enable_regs = merge16(st_reg.source_enable_regs, wval, st_reg.w_strb);
        end
        `PITC_TAKEN_VECTOR_OFS: begin
          // Read-only; the write is accepted and dropped
        end
        default: begin
          w_ok = 1'b0;
          for (int k = 0; k < 4; k++) begin
            if (st_reg.aw_addr == `PITC_SOURCE_PRIORITY_OFS + 8'(k * 4)) begin
              w_ok = 1'b1;
              st_next.source_priority_regs[k] = merge16(st_reg.source_priority_regs[k], wval,
                                                        st_reg.w_strb) & `PITC_PRIO_MASK;
            end
          end
        end
      endcase
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = w_ok ? `PITC_RESP_OKAY : `PITC_RESP_SLVERR;
    end else if (st_reg.bvalid && bready) begin
      st_next.bvalid = 1'b0;
    end

    // Hardware sets win over a software clear in the same cycle
    st_next.request_flag_regs = st_next.request_flag_regs | src_evt;
    st_next.global_ctrl_one = st_next.global_ctrl_one | trap_set;
    if (trap_evt) begin
      st_next.cpu_level_top_bit = 1'b1;
    end

    // Acceptance by the core latches the winner and raises the level
    // Nesting disable freezes only software writes, not this update
    if (irq_ack && st_reg.irq_req) begin
      st_next.taken_vector_number = st_reg.irq_vector;
      st_next.new_level_field = st_reg.irq_level;
      st_next.cpu_priority_level = st_reg.irq_level[2:0];
    end

    // Ready stays low while a response waits, so one write at most is in flight
    st_next.awready = !st_next.aw_have && !st_next.bvalid;
    st_next.wready = !st_next.w_have && !st_next.bvalid;

    // Read channel
    r_ok = 1'b1;
    rval = 16'h0000;
    case (araddr)
      `PITC_CPU_STATUS_WORD_OFS: rval[`PITC_LEVEL_LSB +: 3] = st_reg.cpu_priority_level;
      `PITC_CORE_CONTROL_WORD_OFS: rval[`PITC_TOP_BIT] = st_reg.cpu_level_top_bit;
      `PITC_GLOBAL_CTRL_ONE_OFS: rval = st_reg.global_ctrl_one;
      `PITC_GLOBAL_CTRL_TWO_OFS: rval = {st_reg.alternate_table_select, 12'h000,
                                         st_reg.ext_edge_polarity};
      `PITC_REQUEST_FLAG_OFS: rval = st_reg.request_flag_regs;
      `PITC_SOURCE_ENABLE_OFS: rval = st_reg.source_enable_regs;
      `PITC_TAKEN_VECTOR_OFS: rval = {4'h0, st_reg.new_level_field, 1'b0, st_reg.taken_vector_number};
      default: begin
        r_ok = 1'b0;
        for (int k = 0; k < 4; k++) begin
          if (araddr == `PITC_SOURCE_PRIORITY_OFS + 8'(k * 4)) begin
            r_ok = 1'b1;
            rval = st_reg.source_priority_regs[k];
          end
        end
      end
    endcase
    if (arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = rval;
      st_next.rresp = r_ok ? `PITC_RESP_OKAY : `PITC_RESP_SLVERR;
    end else if (st_reg.rvalid && rready) begin
      st_next.rvalid = 1'b0;
    end
    st_next.arready = !st_next.rvalid;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.source_priority_regs <= {4{`PITC_PRIO_WORD_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign awready = st_reg.awready;
  assign wready = st_reg.wready;
  assign bvalid = st_reg.bvalid;
  assign bresp = st_reg.bresp;
  assign arready = st_reg.arready;
  assign rvalid = st_reg.rvalid;
  assign rdata = {16'h0000, st_reg.rdata};
  assign rresp = st_reg.rresp;
  assign irq_req = st_reg.irq_req;
  assign irq_vector = st_reg.irq_vector;
  assign irq_level = st_reg.irq_level;
  assign alternate_table_select = st_reg.alternate_table_select;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  flag_set_a: assert property (periph_req[3] |=> st_reg.request_flag_regs[3])
    else $error("request flag not set by source event");
  enable_gate_a: assert property ((st_reg.request_flag_regs & st_reg.source_enable_regs) == 16'h0000
                                  |=> !st_reg.irq_req)
    else $error("request raised with no enabled flag");
  taken_latch_a: assert property (irq_ack && st_reg.irq_req
                                  |=> st_reg.taken_vector_number == $past(st_reg.irq_vector))
    else $error("taken vector not latched");
  new_level_a: assert property (irq_ack && st_reg.irq_req
                                |=> st_reg.new_level_field == $past(st_reg.irq_level))
    else $error("new level not latched");
  level_seven_a: assert property (st_reg.cpu_priority_level == 3'h7 |=> !st_reg.irq_req)
    else $error("request raised at level seven");
  top_block_a: assert property (st_reg.cpu_level_top_bit |=> !st_reg.irq_req)
    else $error("request raised with top level bit set");
  top_no_sw_a: assert property ($rose(st_reg.cpu_level_top_bit) |-> $past(trap_evt))
    else $error("top level bit set without a trap");
  nest_ro_a: assert property (st_reg.global_ctrl_one[`PITC_NEST_DIS] && !irq_ack
                              |=> $stable(st_reg.cpu_priority_level))
    else $error("level changed while nesting disabled");
  ovf_trap_a: assert property (trap_ovf_a && st_reg.global_ctrl_one[`PITC_OVA_EN]
                               |=> st_reg.global_ctrl_one[`PITC_OVA_FLAG])
    else $error("overflow trap flag not set");
  div_math_a: assert property (trap_div0
                               |=> st_reg.global_ctrl_one[`PITC_DIV0_FLAG] && st_reg.global_ctrl_one[`PITC_MATH_FLAG])
    else $error("divide trap flags not set");
  ext_edge_a: assert property ($rose(st_reg.sync2[0]) && !st_reg.ext_edge_polarity[0]
                               |=> st_reg.request_flag_regs[0])
    else $error("external rising edge not flagged");
  bresp_hold_a: assert property (st_reg.bvalid && !bready |=> st_reg.bvalid && $stable(st_reg.bresp))
    else $error("write response dropped before bready");
  elig_src_a: assert property (st_reg.request_flag_regs[0] && st_reg.source_enable_regs[0]
                               && ({1'b0, st_reg.source_priority_regs[0][2:0]} > cur_level)
                               |=> st_reg.irq_req
                               && (st_reg.irq_level[2:0] >= $past(st_reg.source_priority_regs[0][2:0])))
    else $error("eligible source not requested");
  shift_math_a: assert property (trap_shift |=> st_reg.global_ctrl_one[`PITC_SHIFT_FLAG]
                                 && st_reg.global_ctrl_one[`PITC_MATH_FLAG])
    else $error("shift trap flags not set");
  trap_sticky_a: assert property (st_reg.global_ctrl_one[`PITC_DMA_FLAG]
                                  && !(do_write && st_reg.aw_addr == `PITC_GLOBAL_CTRL_ONE_OFS)
                                  |=> st_reg.global_ctrl_one[`PITC_DMA_FLAG])
    else $error("trap flag cleared without a write");
  trap_top_a: assert property (trap_evt |=> st_reg.cpu_level_top_bit)
    else $error("trap did not raise the top level bit");

  irq_taken_c: cover property (st_reg.irq_req && irq_ack);
  write_done_c: cover property (st_reg.bvalid && bready);
  read_done_c: cover property (st_reg.rvalid && rready);
  ext_flag_c: cover property (ext_edge[1] ##1 st_reg.request_flag_regs[`PITC_EXT1_SRC]);
  trap_block_c: cover property (trap_evt ##1 st_reg.cpu_level_top_bit);

endmodule

`default_nettype wire

// ===== pitc_map.svh
// Register offsets, field positions, reset values and constants of the
// interrupt and trap controller. Assumes an 8-bit AXI4-Lite byte address.
`ifndef PITC_MAP_SVH
`define PITC_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PITC_CPU_STATUS_WORD_OFS 8'h00
`define PITC_CORE_CONTROL_WORD_OFS 8'h04
`define PITC_GLOBAL_CTRL_ONE_OFS 8'h08
`define PITC_GLOBAL_CTRL_TWO_OFS 8'h0C
`define PITC_REQUEST_FLAG_OFS 8'h10
`define PITC_SOURCE_ENABLE_OFS 8'h14
`define PITC_SOURCE_PRIORITY_OFS 8'h18
`define PITC_TAKEN_VECTOR_OFS 8'h28

// ****************************************************************
// Field positions
// ****************************************************************
`define PITC_LEVEL_LSB 5
`define PITC_TOP_BIT 3
`define PITC_NEST_DIS 15
`define PITC_OVA_FLAG 14
`define PITC_OVB_FLAG 13
`define PITC_COVA_FLAG 12
`define PITC_COVB_FLAG 11
`define PITC_OVA_EN 10
`define PITC_OVB_EN 9
`define PITC_COV_EN 8
`define PITC_SHIFT_FLAG 7
`define PITC_DIV0_FLAG 6
`define PITC_DMA_FLAG 5
`define PITC_MATH_FLAG 4
`define PITC_ADDR_FLAG 3
`define PITC_STACK_FLAG 2
`define PITC_OSC_FLAG 1
`define PITC_ALT_TABLE 15
`define PITC_NEW_LEVEL_LSB 8
`define PITC_CTRL_ONE_MASK 16'hFFFE
`define PITC_PRIO_MASK 16'h7777

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define PITC_PRIO_WORD_RST 16'h4444
`define PITC_VEC_BASE 7'h08
`define PITC_EXT1_SRC 14
`define PITC_EXT2_SRC 15
`define PITC_RESP_OKAY 2'b00
`define PITC_RESP_SLVERR 2'b10

`endif

// ===== pitc_pkg.sv
// Types of the interrupt and trap controller.
// Assumes pitc_map.svh is compiled alongside.
package pitc_pkg;

  typedef struct packed {
    // Bus slave
    logic aw_have;
    logic w_have;
    logic [7:0] aw_addr;
    logic [15:0] w_data;
    logic [1:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [15:0] rdata;
    // Priority state
    logic [2:0] cpu_priority_level;
    logic cpu_level_top_bit;
    logic [15:0] global_ctrl_one;
    logic alternate_table_select;
    logic [2:0] ext_edge_polarity;
    logic [15:0] request_flag_regs;
    logic [15:0] source_enable_regs;
    logic [3:0][15:0] source_priority_regs;
    logic [6:0] taken_vector_number;
    logic [3:0] new_level_field;
    // External pin synchroniser and edge stage
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    // Core side
    logic irq_req;
    logic [6:0] irq_vector;
    logic [3:0] irq_level;
  } pitc_state_t;

endpackage

// ===== pitc_core_stub.sv
// Core-side stand-in for the interrupt and trap controller.
// Assumes irq_req is a level that falls within a few cycles of an ack.
`timescale 1ns/1ps
`default_nettype none

module pitc_core_stub (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request from the controller
  input wire logic irq_req,
  input wire logic [6:0] irq_vector,
  input wire logic [3:0] irq_level,
  // Control from the bench
  input wire logic ack_en,
  input wire logic [3:0] ack_wait,
  // Answer and record
  output logic irq_ack,
  output logic [6:0] got_vec,
  output logic [3:0] got_lvl
);
  logic [3:0] wait_reg;
  logic [3:0] hold_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_reg <= 4'h0;
      hold_reg <= 4'h0;
      irq_ack <= 1'b0;
      got_vec <= 7'h0;
      got_lvl <= 4'h0;
    end else begin
      irq_ack <= 1'b0;
      // Hold-off: the request lags the level update, so never ack twice
      if (hold_reg != 4'h0) begin
        hold_reg <= hold_reg - 4'h1;
      end else if (!(ack_en && irq_req)) begin
        wait_reg <= 4'h0;
      end else if (wait_reg < ack_wait) begin
        wait_reg <= wait_reg + 4'h1;
      end else begin
        irq_ack <= 1'b1;
        got_vec <= irq_vector;
        got_lvl <= irq_level;
        hold_reg <= 4'h4;
        wait_reg <= 4'h0;
      end
    end
  end
endmodule

`default_nettype wire

// ===== pitc_ctrl_test.sv
// Directed testbench of the interrupt and trap controller over AXI4-Lite.
// Assumes pitc_core_stub answers requests on the core side.
`timescale 1ns/1ps
`default_nettype none

module pitc_ctrl_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [15:0] preq = 16'h0;
  logic [2:0] pin = 3'h0;
  logic [9:0] trap = 10'h0;
  logic ack_en = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid, irq_req, irq_ack, alt;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [6:0] vec, mvec;
  wire logic [3:0] lvl, mlvl;
  int num_errors = 0;
  int n_checks = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  // Flag bits each trap event should raise, in trap vector order
  logic [15:0] tbits [10] = '{16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0090,
                              16'h0050, 16'h0020, 16'h0008, 16'h0004, 16'h0002};

  always #50 aclk = ~aclk;

  pitc_ctrl i_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .periph_req(preq), .ext_irq_pin(pin), .trap_ovf_a(trap[0]), .trap_ovf_b(trap[1]),
    .trap_cat_a(trap[2]), .trap_cat_b(trap[3]), .trap_shift(trap[4]), .trap_div0(trap[5]),
    .trap_dma(trap[6]), .trap_addr(trap[7]), .trap_stack(trap[8]), .trap_osc(trap[9]),
    .irq_req(irq_req), .irq_vector(vec), .irq_level(lvl), .irq_ack(irq_ack),
    .alternate_table_select(alt));

  pitc_core_stub i_core (.aclk(aclk), .aresetn(aresetn), .irq_req(irq_req),
    .irq_vector(vec), .irq_level(lvl), .ack_en(ack_en), .ack_wait(4'h3),
    .irq_ack(irq_ack), .got_vec(mvec), .got_lvl(mlvl));

  // ****************************************************************
  // Bus tasks, entered and left just after a rising edge
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bit ad;
    bit dd;
    ad = 0;
    dd = 0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= {16'h0, d};
    wstrb <= 4'hf;
    bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      if (awready && !ad) begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (wready && !dd) begin
        dd = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
    // An idle edge keeps the next call from reassigning bready in this step
    @(posedge aclk);
  endtask

  task automatic rdr(input logic [7:0] a);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    chk(n, rd, e);
  endtask

  task automatic pulse(input logic [15:0] m);
    preq <= m;
    @(posedge aclk);
    preq <= 16'h0;
    cyc(3);
  endtask

  task automatic test_done;
    $display("Checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    #(100 * 6000);
    num_errors++;
    $display("ERROR watchdog expired");
    test_done;
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    cyc(2);
    aresetn <= 1'b1;
    cyc(1);
    rc("status", 8'h00, 32'h0);
    rc("core", 8'h04, 32'h0);
    rc("ctrl one", 8'h08, 32'h0);
    rc("ctrl two", 8'h0c, 32'h0);
    rc("prio", 8'h18, 32'h4444);
    rc("prio last", 8'h24, 32'h4444);
    rdr(8'h2c);
    chk("unmapped resp", 32'(rs), 32'h2);
    $display("Reset values finished");
    wr(8'h18, 16'hffff);
    chk("write resp", 32'(rs), 32'h0);
    rc("prio mask", 8'h18, 32'h7777);
    wr(8'h18, 16'h3355);
    wr(8'h14, 16'h000f);
    pulse(16'h000c);
    chk("tie vector", 32'(vec), 32'ha);
    chk("tie level", 32'(lvl), 32'h3);
    pulse(16'h0001);
    chk("first vector", 32'(vec), 32'h8);
    chk("first level", 32'(lvl), 32'h5);
    wr(8'h14, 16'h000e);
    cyc(3);
    chk("masked source", 32'(vec), 32'ha);
    wr(8'h14, 16'h000f);
    wr(8'h00, 16'h00e0);
    cyc(3);
    chk("level seven", 32'(irq_req), 32'h0);
    wr(8'h00, 16'h0080);
    cyc(3);
    chk("above level", 32'(vec), 32'h8);
    wr(8'h00, 16'h00a0);
    cyc(3);
    chk("equal level", 32'(irq_req), 32'h0);
    $display("Arbitration finished");
    wr(8'h00, 16'h0000);
    ack_en <= 1'b1;
    cyc(12);
    ack_en <= 1'b0;
    chk("acked vector", 32'(mvec), 32'h8);
    chk("acked level", 32'(mlvl), 32'h5);
    rc("taken reg", 8'h28, 32'h0508);
    rc("new level", 8'h00, 32'h00a0);
    rc("flags kept", 8'h10, 32'h000d);
    wr(8'h10, 16'h0000);
    rc("flags cleared", 8'h10, 32'h0);
    $display("Acknowledge finished");
    wr(8'h08, 16'h8000);
    rc("nest off", 8'h08, 32'h8000);
    wr(8'h00, 16'h0020);
    rc("level frozen", 8'h00, 32'h00a0);
    wr(8'h08, 16'h0000);
    wr(8'h00, 16'h0020);
    rc("level written", 8'h00, 32'h0020);
    $display("Nesting finished");
    wr(8'h0c, 16'h8001);
    rc("ctrl two rw", 8'h0c, 32'h8001);
    chk("alt table", 32'(alt), 32'h1);
    pin <= 3'h1;
    cyc(6);
    rc("rise ignored", 8'h10, 32'h0);
    pin <= 3'h0;
    cyc(6);
    rc("fall taken", 8'h10, 32'h0001);
    pin <= 3'h6;
    cyc(6);
    rc("rise taken", 8'h10, 32'hc001);
    wr(8'h0c, 16'h0000);
    chk("alt table off", 32'(alt), 32'h0);
    $display("External pins finished");
    trap <= 10'h00f;
    cyc(1);
    trap <= 10'h0;
    cyc(2);
    rc("disabled traps", 8'h08, 32'h0);
    wr(8'h10, 16'h0000);
    pulse(16'h0001);
    chk("pending", 32'(irq_req), 32'h1);
    wr(8'h08, 16'h0700);
    for (int i = 0; i < 10; i++) begin
      trap <= 10'(1 << i);
      cyc(1);
      trap <= 10'h0;
      cyc(3);
      rc("trap flags", 8'h08, {16'h0, 16'h0700 | tbits[i]});
      rc("top bit", 8'h04, 32'h0008);
      chk("blocked", 32'(irq_req), 32'h0);
      wr(8'h08, 16'h0700);
      wr(8'h04, 16'h0000);
    end
    wr(8'h04, 16'h0000);
    cyc(3);
    chk("unblocked", 32'(irq_req), 32'h1);
    wr(8'h04, 16'h0008);
    rc("top bit locked", 8'h04, 32'h0);
    $display("Traps finished");
    test_done;
  end
endmodule

`default_nettype wire
